// *** core/sfrd_cfield_dec.sv ***
// Combinational control-field and data-field decoder for one frame.
// Assumes the frame window holds the control field in bits 23:20.
`timescale 1ns/10ps
`include "sfrd_defines.svh"
module sfrd_cfield_dec (
   input  wire logic        [23:0] frame_i,
   input  wire logic               wide_i,
   input  wire logic               flag_data_i,
   input  wire logic               dfs_i,
   input  wire logic               prev_flag_i,
   output sfrd_pkg::sfrd_frame_t   dec_o
);
   logic [3:0]  cf;
   logic        inv;
   logic [1:0]  code;
   logic [19:0] raw;
   logic [19:0] pay;
   logic        bad_fill;
   logic        bad_flag;

   always_comb begin
      cf   = frame_i[23:20];
      inv  = (cf[3:2] == `SFRD_MT_INV);
      code = inv ? ~cf[1:0] : cf[1:0];
      raw  = wide_i ? frame_i[19:0] : {4'h0, frame_i[19:4]};
      pay  = inv ? (raw ^ (wide_i ? 20'hF_FFFF : 20'h0_FFFF)) : raw;
      dec_o = '0;
      dec_o.payload = pay;
      dec_o.mt_ok   = (cf[3:2] == `SFRD_MT_NORM) || inv;
      dec_o.ctrl_n  = (code != `SFRD_CODE_CTRL);
      dec_o.data_n  = (code[1] != 1'h1);
      dec_o.flag    = (code == `SFRD_CODE_DATA1);
      dec_o.fill_type = (code == `SFRD_CODE_FILL) && pay[0];
      bad_fill = (code == `SFRD_CODE_FILL) && (pay[19:1] != 19'h0_0000);
      // Without flag-as-data the flag checks frame parity when DFS is set, and must be low when DFS is clear
      bad_flag = !flag_data_i && code[1] &&
                 (dfs_i ? (dec_o.flag == prev_flag_i) : dec_o.flag);
      dec_o.error = !dec_o.mt_ok || bad_fill || bad_flag;
   end
endmodule

// *** core/sfrd_receiver.sv ***
// Receive decoder: frame demux, field decode, link state machine,
// Wishbone control and status registers.
// Assumes clk_i is the recovered serial bit clock, one bit per cycle,
// and that pins reach it through the two-stage synchroniser.
//
// Notes on behaviour
// - Sample serial input on recovered bit clock.
// - Frame is 20 bits, or 24 wide.
// - Top four bits control, rest data.
// - Control field gives type and inversion.
// - Valid flags low per type; fill both high.
// - Control field errors feed state machine.
// - Flag-as-data restores flag as data bit.
// - Otherwise flag marks even or odd frame.
// - Data field restored using decoder decision.
// - Both reset pins low restart link.
// - Two outputs encode the link state.
// - Ready pin resampled by frame strobe.
// - Strobe falls at boundary, rises mid-frame.
// - Outputs update after strobe falling edge.
// - Outputs lag input by two frames.
// - Link state changes only at boundary.
// - Reset or error forces state zero.
// - State zero for 128 frames, then one.
// - Later states follow received training fills.
// - Wide select expects 24-bit frames.
// - Master transition aligns frame boundaries.
// - Flag-as-data must match transmitter setting.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "sfrd_defines.svh"
module sfrd_receiver #(
   parameter int S0_FRAMES = `SFRD_S0_FRAMES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        serial_data_i,
   input  wire logic        link_up_request_i,
   input  wire logic        link_sm_reset0_n_i,
   input  wire logic        link_sm_reset1_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [19:0] payload_o,
   output logic             control_word_valid_n_o,
   output logic             data_word_valid_n_o,
   output logic             fill_frame_type_o,
   output logic             error_o,
   output logic             flag_o,
   output logic             link_state_hi_o,
   output logic             link_state_lo_o,
   output logic             link_ready_n_o,
   output logic             recovered_frame_strobe_o
);
   if (S0_FRAMES < 2 || S0_FRAMES > 128) begin : g_chk
      $error("S0_FRAMES must lie in 2..128");
   end

   localparam logic [6:0] S0_LAST = 7'(S0_FRAMES - 1);

   sfrd_pkg::sfrd_top_st_t st;
   sfrd_pkg::sfrd_top_st_t next_st;
   sfrd_pkg::sfrd_frame_t  dec;

   logic [3:0]  pins_s;
   logic        sin;
   logic        act_s;
   logic        lrst;
   logic [4:0]  len;
   logic [4:0]  half;
   logic        last;
   logic [23:0] frame;
   logic        wb_req;
   logic [5:0]  widx;

   // Pins cross into the bit clock domain
   sfrd_sync2 #(
      .W       (4),
      .RST_VAL (`SFRD_SYNC_RST)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   ({link_sm_reset1_n_i, link_sm_reset0_n_i,
               link_up_request_i, serial_data_i}),
      .q_o   (pins_s)
   );

   assign sin   = pins_s[0];
   assign act_s = pins_s[1];
   assign lrst  = !pins_s[2] && !pins_s[3];

   sfrd_cfield_dec u_dec (
      .frame_i     (frame),
      .wide_i      (st.ctrl[`SFRD_CTRL_WIDE]),
      .flag_data_i (st.ctrl[`SFRD_CTRL_FLAG]),
      .dfs_i       (st.ctrl[`SFRD_CTRL_DFS]),
      .prev_flag_i (st.prev_flag),
      .dec_o       (dec)
   );

   assign frame = {sin, st.sr[23:1]};

   always_comb begin
      next_st = st;
      len  = st.ctrl[`SFRD_CTRL_WIDE] ? `SFRD_LEN_WIDE : `SFRD_LEN_NARROW;
      half = st.ctrl[`SFRD_CTRL_WIDE] ? `SFRD_HALF_WIDE : `SFRD_HALF_NARROW;
      // A shrink of the frame size wraps the position at once
      last = (st.cnt >= len - 5'h01);
      wb_req = wb_cyc_i && wb_stb_i && !st.ack;
      widx = wb_adr_i[7:2];

      // Demux: newest bit enters at the top of the window
      next_st.sr = frame;

      if (last) begin
         // Missing master transition slips the window by one bit
         if (dec.mt_ok) begin
            next_st.cnt = 5'h00;
         end else begin
            next_st.cnt = st.cnt;
         end
         next_st.stage = dec;
         next_st.out   = st.stage;
         next_st.rdy_n = !act_s;
         if (!dec.data_n && dec.mt_ok) begin
            next_st.prev_flag = dec.flag;
         end

         // Link state machine steps once per frame
         if (lrst || st.stage.error) begin
            next_st.lstate = sfrd_pkg::SFRD_S0;
            next_st.s0cnt  = 7'h00;
         end else begin
            case (st.lstate)
               sfrd_pkg::SFRD_S0: begin
                  if (st.s0cnt == S0_LAST) begin
                     next_st.lstate = sfrd_pkg::SFRD_S1;
                  end else begin
                     next_st.s0cnt = st.s0cnt + 7'h01;
                  end
               end
               sfrd_pkg::SFRD_S1: begin
                  // Any training fill shows the far end in lock
                  if (st.stage.ctrl_n && st.stage.data_n) begin
                     next_st.lstate = sfrd_pkg::SFRD_S2;
                  end
               end
               sfrd_pkg::SFRD_S2: begin
                  // Second training fill shows the far end ready
                  if (st.stage.ctrl_n && st.stage.data_n &&
                      st.stage.fill_type) begin
                     next_st.lstate = sfrd_pkg::SFRD_S3;
                  end
               end
               sfrd_pkg::SFRD_S3: begin
                  next_st.lstate = sfrd_pkg::SFRD_S3;
               end
               default: begin
                  next_st.lstate = sfrd_pkg::SFRD_S0;
               end
            endcase
         end
      end else begin
         next_st.cnt = st.cnt + 5'h01;
      end

      // Strobe falls only at a boundary and rises only at mid-frame,
      // so a frame-size change cannot make a stray edge
      if (last && dec.mt_ok) begin
         next_st.strb = 1'b0;
      end else if (next_st.cnt == half) begin
         next_st.strb = 1'b1;
      end

      // Wishbone slave, one wait state, unmapped reads zero
      next_st.ack = wb_req;
      if (wb_req) begin
         next_st.rdat = 32'h0000_0000;
         case (widx)
            `SFRD_ADR_CTRL: begin
               next_st.rdat[2:0] = st.ctrl;
               if (wb_we_i && wb_sel_i[0]) begin
                  next_st.ctrl = wb_dat_i[2:0];
               end
            end
            `SFRD_ADR_STATUS: begin
               next_st.rdat[3:0] = {st.out.error, st.rdy_n, st.lstate};
            end
            default: begin
               next_st.rdat = 32'h0000_0000;
            end
         endcase
      end

      if (!ce_i) begin
         next_st = st;
      end

      if (rst_i) begin
         next_st           = '0;
         next_st.ctrl      = `SFRD_CTRL_RST;
         next_st.stage.ctrl_n = 1'h1;
         next_st.stage.data_n = 1'h1;
         next_st.out.ctrl_n   = 1'h1;
         next_st.out.data_n   = 1'h1;
         next_st.rdy_n     = 1'h1;
         next_st.lstate    = sfrd_pkg::SFRD_S0;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign payload_o                = st.out.payload;
   assign control_word_valid_n_o   = st.out.ctrl_n;
   assign data_word_valid_n_o      = st.out.data_n;
   assign fill_frame_type_o        = st.out.fill_type;
   assign error_o                  = st.out.error;
   assign flag_o                   = st.out.flag;
   assign link_state_hi_o          = st.lstate[1];
   assign link_state_lo_o          = st.lstate[0];
   assign link_ready_n_o           = st.rdy_n;
   assign recovered_frame_strobe_o = st.strb;
   assign wb_dat_o                 = st.rdat;
   assign wb_ack_o                 = st.ack;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s0_done_s;
      st.lstate == sfrd_pkg::SFRD_S0 && st.s0cnt == S0_LAST &&
      last && ce_i && !lrst && !st.stage.error;
   endsequence

   sequence wb_req_s;
      wb_req && ce_i;
   endsequence

   sequence wb_done_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   strobe_fall_a: assert property (
      $fell(recovered_frame_strobe_o) |-> st.cnt == 5'h00)
      else $error("Strobe fell away from a frame boundary");

   strobe_mid_a: assert property (
      $rose(recovered_frame_strobe_o) |-> st.cnt == $past(half))
      else $error("Strobe rose away from mid-frame");

   state_edge_a: assert property (
      $changed(st.lstate) |-> $past(last && ce_i))
      else $error("Link state changed between boundaries");

   s0_exit_a: assert property (
      s0_done_s |=> st.lstate == sfrd_pkg::SFRD_S1)
      else $error("State zero not left after its frame count");

   sm_reset_a: assert property (
      (last && ce_i && lrst) |=>
         st.lstate == sfrd_pkg::SFRD_S0 && st.s0cnt == 7'h00)
      else $error("Reset pins did not restart the link");

   valid_excl_a: assert property (
      !(!control_word_valid_n_o && !data_word_valid_n_o))
      else $error("Control and data valid both low");

   err_state_a: assert property (
      $rose(error_o) |-> st.lstate == sfrd_pkg::SFRD_S0)
      else $error("Error output without return to state zero");

   ready_take_a: assert property (
      (last && ce_i) |=> link_ready_n_o == !$past(act_s))
      else $error("Ready output not resampled at boundary");

   latency_a: assert property (
      (last && ce_i) |=> payload_o == $past(st.stage.payload) &&
         st.stage.payload == $past(dec.payload))
      else $error("Payload pipeline is not two frames deep");

   wb_ack_a: assert property (
      wb_req_s |=> wb_done_s)
      else $error("Bus ack not a single cycle after request");

   // Bus answers only what was asked
   ack_idle_a: assert property (
      (ce_i && !(wb_cyc_i && wb_stb_i)) |=> !wb_ack_o)
      else $error("Bus ack without a request");

   // Frame outputs and readiness only move at a boundary
   out_hold_a: assert property (
      !(last && ce_i) |=> $stable(payload_o) && $stable(error_o) &&
         $stable(data_word_valid_n_o) && $stable(control_word_valid_n_o))
      else $error("Frame outputs changed between boundaries");

   ready_hold_a: assert property (
      !(last && ce_i) |=> $stable(link_ready_n_o))
      else $error("Ready output changed between boundaries");

   fill_valid_a: assert property (
      fill_frame_type_o |-> control_word_valid_n_o && data_word_valid_n_o)
      else $error("Fill type shown on a control or data frame");

   // A frame without master transition is an error and slips the window
   mt_err_a: assert property (
      (last && ce_i && !dec.mt_ok) |=> st.stage.error)
      else $error("Missing master transition not flagged");

   slip_a: assert property (
      (last && ce_i && !dec.mt_ok) |=> st.cnt == $past(st.cnt))
      else $error("Window did not slip on a missing transition");

   // Startup waits out its frame count, then follows training fills
   s0_hold_a: assert property (
      (st.lstate == sfrd_pkg::SFRD_S0 && st.s0cnt != S0_LAST) |=>
         st.lstate == sfrd_pkg::SFRD_S0)
      else $error("State zero left before its frame count");

   sequence sm_step_s;
      last && ce_i && !lrst && !st.stage.error;
   endsequence

   train_fill_a: assert property (
      (sm_step_s ##0 (st.lstate == sfrd_pkg::SFRD_S1 && st.stage.ctrl_n &&
         st.stage.data_n)) |=> st.lstate == sfrd_pkg::SFRD_S2)
      else $error("Training fill did not advance state one");

   train_ready_a: assert property (
      (sm_step_s ##0 (st.lstate == sfrd_pkg::SFRD_S2 && st.stage.ctrl_n &&
         st.stage.data_n && st.stage.fill_type)) |=> st.lstate == sfrd_pkg::SFRD_S3)
      else $error("Ready fill did not advance state two");
endmodule

// *** core/sfrd_sync2.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes single clock; stage one feeds stage two only.
`timescale 1ns/10ps
module sfrd_sync2 #(
   parameter int         W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } sfrd_sync_st_t;

   sfrd_sync_st_t st;
   sfrd_sync_st_t next_st;

   always_comb begin
      next_st = st;
      if (rst_i) begin
         next_st.s1 = RST_VAL;
         next_st.s2 = RST_VAL;
      end else if (ce_i) begin
         next_st.s1 = d_i;
         next_st.s2 = st.s1;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign q_o = st.s2;
endmodule

// *** include/sfrd_defines.svh ***
// Constants of the serial frame receive decoder.
// Assumes inclusion by every file that decodes frames or registers.
`ifndef SFRD_DEFINES_SVH
`define SFRD_DEFINES_SVH
`define SFRD_LEN_NARROW 5'h14
`define SFRD_LEN_WIDE 5'h18
`define SFRD_HALF_NARROW 5'h0A
`define SFRD_HALF_WIDE 5'h0C
`define SFRD_S0_FRAMES 128
`define SFRD_MT_NORM 2'h2
`define SFRD_MT_INV 2'h1
`define SFRD_CODE_FILL 2'h0
`define SFRD_CODE_CTRL 2'h1
`define SFRD_CODE_DATA0 2'h2
`define SFRD_CODE_DATA1 2'h3
`define SFRD_ADR_CTRL 6'h00
`define SFRD_ADR_STATUS 6'h01
`define SFRD_CTRL_WIDE 0
`define SFRD_CTRL_FLAG 1
`define SFRD_CTRL_DFS 2
`define SFRD_CTRL_RST 3'h0
`define SFRD_SYNC_RST 4'h0
`endif

// *** include/sfrd_pkg.sv ***
// Types of the serial frame receive decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package sfrd_pkg;
   typedef enum logic [1:0] {
      SFRD_S0 = 2'h0,
      SFRD_S1 = 2'h1,
      SFRD_S2 = 2'h2,
      SFRD_S3 = 2'h3
   } sfrd_lstate_t;

   typedef struct packed {
      logic        ctrl_n;
      logic        data_n;
      logic        fill_type;
      logic        flag;
      logic        error;
      logic        mt_ok;
      logic [19:0] payload;
   } sfrd_frame_t;

   typedef struct packed {
      logic [4:0]   cnt;
      logic [23:0]  sr;
      logic         strb;
      logic [6:0]   s0cnt;
      sfrd_lstate_t lstate;
      logic         prev_flag;
      sfrd_frame_t  stage;
      sfrd_frame_t  out;
      logic         rdy_n;
      logic [2:0]   ctrl;
      logic         ack;
      logic [31:0]  rdat;
   } sfrd_top_st_t;
endpackage

// *** testbench/sfrd_tx_model.sv ***
// Serial transmitter model feeding the receiver one frame per call.
// Assumes the caller sends frames back to back so the line never idles.
`timescale 1ns/10ps
module sfrd_tx_model (
   input  wire logic clk_i,
   output logic      serial_o
);
   initial serial_o = 1'b0;

   // Bit 0 first, control field last; narrow frames skip bits 3:0
   task automatic send(input logic [23:0] f, input logic wide, output int t0);
      int i;
      for (i = wide ? 0 : 4; i < 24; i++) begin
         @(posedge clk_i);
         if (i == (wide ? 0 : 4))
            t0 = int'($time / 40);
         serial_o <= f[i];
      end
   endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the serial frame receive decoder.
// Assumes sfrd_tx_model on the serial line and one 25 MHz clock.
`timescale 1ns/10ps
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        serial;
   logic        req = 1'b0;
   logic        r0_n = 1'b1;
   logic        r1_n = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [19:0] pay;
   logic        ack, cvn, dvn, fft, err, flg, shi, slo, rdyn, strb;
   logic        wide = 1'b0, fad = 1'b0, dfs = 1'b0, pflag = 1'b0;
   logic        chk_en = 1'b0, inject = 1'b0, ps = 1'b0;
   int          mix = 0, tf = 0, cycles = 0, m;
   int          mismatches = 0, total_checks = 0;
   int          seed = 32'h0baf;
   int          st_q[$], k_q[$];
   sfrd_pkg::sfrd_frame_t e_q[$];
   logic [2:0]  tbl [4] = '{3'h0, 3'h3, 3'h4, 3'h1};

   always #20 clk_i = ~clk_i;

   sfrd_tx_model tx (.clk_i(clk_i), .serial_o(serial));

   sfrd_receiver #(.S0_FRAMES(4)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .serial_data_i(serial),
      .link_up_request_i(req), .link_sm_reset0_n_i(r0_n), .link_sm_reset1_n_i(r1_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .payload_o(pay),
      .control_word_valid_n_o(cvn), .data_word_valid_n_o(dvn), .fill_frame_type_o(fft),
      .error_o(err), .flag_o(flg), .link_state_hi_o(shi), .link_state_lo_o(slo),
      .link_ready_n_o(rdyn), .recovered_frame_strobe_o(strb));

   // Readiness request follows the link state
   always @(posedge clk_i) req <= shi & slo;

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test;
      $display("TB: checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic end_test(input string s);
      $display("Test %s done, mismatches %0d", s, mismatches);
   endtask

   task automatic frames(input int n);
      repeat (n * (wide ? 24 : 20)) @(posedge clk_i);
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
         chk("bus ack", 0, 1);
   endtask

   // Endless frame source; settling fills alternate inversion so framing is unique
   initial begin : sender
      logic [23:0] f;
      logic [19:0] d;
      logic [1:0]  c;
      logic        inv, fl;
      sfrd_pkg::sfrd_frame_t e;
      int          k, n, t0;
      n = 0;
      forever begin
         k = mix == 2 ? ($random(seed) & 3) : mix;
         if (inject) begin
            k = 4;
            inject = 1'b0;
         end
         inv = mix == 2 ? 1'($random(seed)) : n[0];
         d = 20'($random(seed));
         if (!wide)
            d[19:16] = 4'h0;
         if (k < 2)
            d = 20'(k);
         if (k == 4)
            d = 20'h0_0002;
         fl = fad ? 1'($random(seed)) : dfs & ~pflag;
         c = k == 2 ? 2'h1 : k == 3 ? {1'b1, fl} : 2'h0;
         if (k == 3)
            pflag = fl;
         f = wide ? {2'h2, c, d} : {2'h2, c, d[15:0], 4'h0};
         if (inv)
            f = ~f;
         e = '0;
         e.ctrl_n = k != 2;
         e.data_n = k != 3;
         e.fill_type = d[0];
         e.flag = c[0];
         e.payload = d;
         tx.send(f, wide, t0);
         st_q.push_back(t0);
         k_q.push_back(k);
         e_q.push_back(e);
         n++;
      end
   end

   // Each strobe fall shows the frame that began two to three frames earlier
   always @(posedge clk_i) begin : monitor
      int i, now, len;
      sfrd_pkg::sfrd_frame_t e;
      len = wide ? 24 : 20;
      now = int'($time / 40);
      if (ps && !strb) begin
         if (chk_en) begin
            chk("strobe period", now - tf, len);
            i = st_q.size() - 1;
            while (i > 0 && st_q[i] > now - 2 * len)
               i--;
            e = e_q[i];
            if (k_q[i] == 4) begin
               chk("error", err, 1);
               chk("state on error", {shi, slo}, 0);
            end else begin
               chk("error", err, 0);
               chk("control valid_n", cvn, e.ctrl_n);
               chk("data valid_n", dvn, e.data_n);
               if (k_q[i] < 2)
                  chk("fill type", fft, e.fill_type);
               else
                  chk("payload", pay, e.payload);
               if (k_q[i] == 3)
                  chk("flag", flg, e.flag);
            end
         end
         tf = now;
      end
      if (chk_en && !ps && strb)
         chk("strobe rise", now - tf, len / 2);
      ps = strb;
      cycles++;
      if (cycles > 20000) begin
         mismatches++;
         stop_test;
      end
   end

   initial begin : main
      logic [31:0] q;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      frames(12);
      chk("state after settle", {shi, slo}, 2);
      wb(1'b0, 8'h04, 0, q);
      chk("status state", q[1:0], 2);
      wb(1'b0, 8'h40, 0, q);
      chk("unmapped read", q, 0);
      end_test("startup");
      mix = 1;
      frames(8);
      chk("state trained", {shi, slo}, 3);
      chk("link ready", rdyn, 0);
      r0_n <= 1'b0;
      frames(4);
      chk("one reset pin", {shi, slo}, 3);
      r1_n <= 1'b0;
      frames(3);
      chk("both reset pins", {shi, slo}, 0);
      chk("link not ready", rdyn, 1);
      r0_n <= 1'b1;
      r1_n <= 1'b1;
      frames(10);
      chk("state retrained", {shi, slo}, 3);
      end_test("link states");
      for (m = 0; m < 4; m++) begin
         chk_en = 1'b0;
         mix = 0;
         wb(1'b1, 8'h00, {29'h0, tbl[m]}, q);
         wide = tbl[m][0];
         fad = tbl[m][1];
         dfs = tbl[m][2];
         frames(8);
         // Unchecked data frames bring both sides' frame parity into step
         mix = 3;
         frames(2);
         mix = 2;
         frames(4);
         chk_en = 1'b1;
         frames(20);
         inject = 1'b1;
         frames(6);
         wb(1'b0, 8'h00, 0, q);
         chk("control readback", q, {29'h0, tbl[m]});
         end_test("frame mode");
      end
      stop_test;
   end
endmodule
